// >>> rtl/dpdp_map.svh
// Purpose: constants of the dual port data path
// Assumes: included by the top module only
// Notes: offsets are byte addresses on the register bus
`ifndef DPDP_MAP_SVH
`define DPDP_MAP_SVH
`define DPDP_OFS_CTRL 8'h00
`define DPDP_OFS_STAT 8'h04
`define DPDP_OFS_IRQST 8'h08
`define DPDP_OFS_IRQMSK 8'h0C
`define DPDP_OFS_CS1 8'h10
`define DPDP_OFS_CS2 8'h14
`define DPDP_OFS_OUTPUT_BUFFER 8'h18
`define DPDP_OFS_RDBUS 8'h1C
`define DPDP_CTRL_MASTER 0
`define DPDP_CTRL_PORTA 1
`define DPDP_CTRL_TOHOST 2
`define DPDP_CTRL_WRITE 3
`define DPDP_CTRL_LOAD 4
`define DPDP_CTRL_GATE 6:5
`define DPDP_IRQ_PE 0
`define DPDP_IRQ_START 1
`define DPDP_CNT_FULL 7'd64
`define DPDP_CNT_HALF 7'd32
`define DPDP_CNT_QTR 7'd16
`endif

// >>> rtl/dpdp_pkg.sv
// Purpose: types of the dual port data path
// Assumes: 18-bit host ports, 16-bit read bus
// Notes: none
package dpdp_pkg;
	typedef enum logic [1:0] {
		DPDP_SRC_CS1 = 2'b00,
		DPDP_SRC_CS2 = 2'b01,
		DPDP_SRC_REMOTE = 2'b11,
		DPDP_SRC_BUFFER = 2'b10
	} dpdp_src_t;
	typedef struct packed {
		logic [17:0] dataIn;
		logic [17:0] dataOut;
		logic dataOe;
	} dpdp_port_t;
	typedef struct packed {
		logic [1:0] narrowStrap;
		logic fullStrap;
		logic halfStrap;
		logic quarterStrap;
	} dpdp_strap_t;
	typedef struct packed {
		logic master;
		logic firstPortSelect;
		logic towardHostDirection;
		logic writeXfer;
		logic gateOn;
		dpdp_src_t gateSrc;
		logic [7:0] cs1;
		logic [7:0] cs2;
		logic [17:0] outputBuffer;
		logic [1:0] irqStatus;
		logic [1:0] irqMask;
		logic [6:0] startCount;
		logic strobeMeta;
		logic strobeSync;
		logic strobeLast;
		logic [17:0] aMeta;
		logic [17:0] aSync;
		logic [17:0] bMeta;
		logic [17:0] bSync;
		logic [15:0] ctlMeta;
		logic [15:0] ctlSync;
		dpdp_strap_t strapMeta;
		dpdp_strap_t strapSync;
		logic [17:0] aOut;
		logic aOeN;
		logic [17:0] bOut;
		logic bOeN;
		logic run;
		logic parityEnable;
		logic irq;
		logic hready;
		logic [31:0] hrdata;
		logic wrPend;
		logic [7:0] wrAddr;
	} dpdp_state_t;
endpackage

// >>> rtl/dual_port_data_path.sv
// Purpose: dual host port data path with read bus mux and start counter
// Assumes: pins and straps are asynchronous and synchronised here
// Notes: registers over AHB-Lite, zero wait state
// Function
// R1: second port drives: master, second, toward host
// R2: first port drives: master, toward host, first
// R3: second port unstrapped: lines 16,17 data
// R4: first port unstrapped: lines 16,17 data
// R5: selected port strapped: parity check enabled
// R6: strobe with upper-only parity sets error
// R7: remote gate routes drive control lines
// R8: buffer gate routes low buffer bits
// R9: read bus goes onto first port 0-15
// R10: first port receives all eighteen lines; the code clears lines 16,17 when the selected port is strapped
// R11: transfer load clears start counter
// R12: write strobe increments start counter
// R13: start at 64, 32 or 16
// R14: no threshold strap: start always; the code starts after the first counted write strobe
// R15: write run asserts once start reached
// R16: status reads gate control low bytes
// R17: port choice bit selects first port
// R18: one source at a time, else zero
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
module dual_port_data_path
	import dpdp_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// host ports
	input wire logic [17:0] firstPortIn,
	output logic [17:0] firstPortOut,
	output logic firstPortOe_n,
	input wire logic [17:0] secondPortIn,
	output logic [17:0] secondPortOut,
	output logic secondPortOe_n,
	input wire logic wordStrobe,
	// drive side and straps
	input wire logic [15:0] driveControlIn,
	input wire dpdp_pkg::dpdp_strap_t straps,
	output logic driveRun,
	output logic parityCheckEnable,
	output logic irq
);
	import dpdp_pkg::*;
	`include "dpdp_map.svh"

	dpdp_state_t s_ff;
	dpdp_state_t nxt_s;
	logic strobeEdge;
	logic firstWideData;
	logic secondWideData;
	logic startReached;
	logic [17:0] selIn;
	logic [17:0] rxData;
	logic [15:0] internalReadBus;
	logic [1:0] events;
	logic [1:0] w1c;
	logic [31:0] rdMux;
	logic addrOk;

	////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_s = s_ff;
		// input synchronisers
		nxt_s.strobeMeta = wordStrobe;
		nxt_s.strobeSync = s_ff.strobeMeta;
		nxt_s.strobeLast = s_ff.strobeSync;
		nxt_s.aMeta = firstPortIn;
		nxt_s.aSync = s_ff.aMeta;
		nxt_s.bMeta = secondPortIn;
		nxt_s.bSync = s_ff.bMeta;
		nxt_s.ctlMeta = driveControlIn;
		nxt_s.ctlSync = s_ff.ctlMeta;
		nxt_s.strapMeta = straps;
		nxt_s.strapSync = s_ff.strapMeta;
		strobeEdge = s_ff.strobeSync & ~s_ff.strobeLast;

		// R17: port choice select
		selIn = s_ff.firstPortSelect ? s_ff.aSync : s_ff.bSync;
		// R4: first port wide
		firstWideData = s_ff.firstPortSelect &
			~s_ff.strapSync.narrowStrap[0];
		// R3: second port wide
		secondWideData = ~s_ff.firstPortSelect &
			~s_ff.strapSync.narrowStrap[1];
		// R10: receive all lines
		rxData = selIn;
		if (!(firstWideData | secondWideData)) begin
			rxData[17:16] = 2'b00;
		end
		// R5: parity enable strap
		nxt_s.parityEnable = ~(firstWideData | secondWideData);

		// R18: single source mux
		internalReadBus = 16'h0000;
		if (s_ff.gateOn) begin
			unique case (s_ff.gateSrc)
				// R7: remote register read
				DPDP_SRC_REMOTE: internalReadBus = s_ff.ctlSync;
				// R8: buffer maintenance read
				DPDP_SRC_BUFFER: internalReadBus = s_ff.outputBuffer[15:0];
				// R16: status low bytes
				DPDP_SRC_CS1: internalReadBus = {8'h00, s_ff.cs1};
				DPDP_SRC_CS2: internalReadBus = {8'h00, s_ff.cs2};
			endcase
		end

		// R12: count write strobes
		if (s_ff.writeXfer && strobeEdge && s_ff.startCount != 7'h7F) begin
			nxt_s.startCount = s_ff.startCount + 7'd1;
		end
		if (s_ff.writeXfer && strobeEdge) begin
			nxt_s.outputBuffer = rxData;
		end
		// R13: start thresholds
		startReached =
			(s_ff.strapSync.fullStrap &&
			s_ff.startCount >= `DPDP_CNT_FULL) ||
			(s_ff.strapSync.halfStrap &&
			s_ff.startCount >= `DPDP_CNT_HALF) ||
			(s_ff.strapSync.quarterStrap &&
			s_ff.startCount >= `DPDP_CNT_QTR) ||
			// R14: no strap always start
			!(s_ff.strapSync.fullStrap | s_ff.strapSync.halfStrap |
			s_ff.strapSync.quarterStrap);
		// R15: run once filled
		nxt_s.run = s_ff.writeXfer && startReached &&
			s_ff.startCount != 7'd0;

		// R6: parity error detect
		events[`DPDP_IRQ_PE] = s_ff.parityEnable && strobeEdge &&
			selIn[17] && !selIn[16];
		events[`DPDP_IRQ_START] = nxt_s.run & ~s_ff.run;

		// R2: first port drivers
		nxt_s.aOeN = ~(s_ff.master & s_ff.towardHostDirection &
			s_ff.firstPortSelect);
		// R9: read bus to first port
		nxt_s.aOut = nxt_s.aOeN ? {2'b00, internalReadBus} :
			s_ff.outputBuffer;
		// R1: second port drivers
		nxt_s.bOeN = ~(s_ff.master & s_ff.towardHostDirection &
			~s_ff.firstPortSelect);
		nxt_s.bOut = s_ff.outputBuffer;

		// bus slave
		addrOk = (haddr[1:0] == 2'b00) && (haddr <= `DPDP_OFS_RDBUS);
		unique case (haddr)
			`DPDP_OFS_CTRL: rdMux = {25'h0, s_ff.gateOn,
				s_ff.gateSrc, s_ff.writeXfer, s_ff.towardHostDirection,
				s_ff.firstPortSelect, s_ff.master};
			`DPDP_OFS_STAT: rdMux = {16'h0, s_ff.run,
				s_ff.parityEnable, 7'h0, s_ff.startCount};
			`DPDP_OFS_IRQST: rdMux = {30'h0, s_ff.irqStatus};
			`DPDP_OFS_IRQMSK: rdMux = {30'h0, s_ff.irqMask};
			`DPDP_OFS_CS1: rdMux = {24'h0, s_ff.cs1};
			`DPDP_OFS_CS2: rdMux = {24'h0, s_ff.cs2};
			`DPDP_OFS_OUTPUT_BUFFER: rdMux = {14'h0, s_ff.outputBuffer};
			`DPDP_OFS_RDBUS: rdMux = {16'h0, internalReadBus};
			default: rdMux = 32'h0000_0000;
		endcase
		nxt_s.hready = 1'b1;
		nxt_s.wrPend = 1'b0;
		if (hsel && hready && htrans[1]) begin
			nxt_s.wrPend = hwrite & addrOk;
			nxt_s.wrAddr = haddr;
			if (!hwrite) begin
				nxt_s.hrdata = addrOk ? rdMux : 32'h0000_0000;
			end
		end
		w1c = 2'b00;
		if (s_ff.wrPend) begin
			unique case (s_ff.wrAddr)
				`DPDP_OFS_CTRL: begin
					nxt_s.master = hwdata[`DPDP_CTRL_MASTER];
					nxt_s.firstPortSelect = hwdata[`DPDP_CTRL_PORTA];
					nxt_s.towardHostDirection = hwdata[`DPDP_CTRL_TOHOST];
					nxt_s.writeXfer = hwdata[`DPDP_CTRL_WRITE];
					nxt_s.gateSrc = dpdp_src_t'(hwdata[`DPDP_CTRL_GATE]);
					nxt_s.gateOn = hwdata[7];
					// R11: load clears counter
					if (hwdata[`DPDP_CTRL_LOAD]) begin
						nxt_s.startCount = 7'd0;
					end
				end
				`DPDP_OFS_IRQST: w1c = hwdata[1:0];
				`DPDP_OFS_IRQMSK: nxt_s.irqMask = hwdata[1:0];
				`DPDP_OFS_CS1: nxt_s.cs1 = hwdata[7:0];
				`DPDP_OFS_CS2: nxt_s.cs2 = hwdata[7:0];
				`DPDP_OFS_OUTPUT_BUFFER: nxt_s.outputBuffer = hwdata[17:0];
				default: w1c = 2'b00;
			endcase
		end
		// set wins over clear
		nxt_s.irqStatus = (s_ff.irqStatus & ~w1c) | events;
		nxt_s.irq = |(nxt_s.irqStatus & s_ff.irqMask);
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
			s_ff.aOeN <= 1'b1;
			s_ff.bOeN <= 1'b1;
			s_ff.hready <= 1'b1;
			s_ff.parityEnable <= 1'b1;
			s_ff.firstPortSelect <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////
	assign hreadyout = s_ff.hready;
	assign hresp = 1'b0;
	assign hrdata = s_ff.hrdata;
	assign firstPortOut = s_ff.aOut;
	assign firstPortOe_n = s_ff.aOeN;
	assign secondPortOut = s_ff.bOut;
	assign secondPortOe_n = s_ff.bOeN;
	assign driveRun = s_ff.run;
	assign parityCheckEnable = s_ff.parityEnable;
	assign irq = s_ff.irq;
endmodule // dual_port_data_path

// >>> test/dpdp_monitor.sv
// Purpose: port checks of the data path
// Assumes: straps held steady between changes
// Notes: bound to the top module
module dpdp_monitor
	import dpdp_pkg::*;
(
	// clock and bus
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// host ports and straps
	input wire logic [17:0] firstPortOut,
	input wire logic firstPortOe_n,
	input wire logic [17:0] secondPortOut,
	input wire logic secondPortOe_n,
	input wire dpdp_pkg::dpdp_strap_t straps,
	input wire logic parityCheckEnable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_none;
		straps.narrowStrap == 2'b00 [*4];
	endsequence
	sequence s_both;
		straps.narrowStrap == 2'b11 [*4];
	endsequence
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_ready_high: assert property (hreadyout == 1'b1)
		else $error("wait state seen");
	a_one_port: assert property (firstPortOe_n || secondPortOe_n)
		else $error("both ports driving");
	a_drive_buffer: assert property (!firstPortOe_n |->
		firstPortOut == secondPortOut) else $error("first port data");
	a_idle_upper: assert property (firstPortOe_n |->
		firstPortOut[17:16] == 2'b00) else $error("read bus upper bits");
	a_parity_off: assert property (s_none |=> !parityCheckEnable)
		else $error("parity on without strap");
	a_parity_on: assert property (s_both |=> parityCheckEnable)
		else $error("parity off with strap");
	a_rdata_hold: assert property (!$stable(hrdata) |->
		$past(hsel && htrans[1] && !hwrite && hready))
		else $error("read data moved");
endmodule // dpdp_monitor
bind dual_port_data_path dpdp_monitor mon (.*);

// >>> test/dpdp_host_model.sv
// Purpose: host memory side of the ports
// Assumes: put is entered on a rising edge
// Notes: lines show inverted data when idle
module dpdp_host_model (
	// host side
	input wire logic mclk,
	output logic [17:0] aData,
	output logic [17:0] bData,
	output logic strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		aData = 18'h0_0000;
		bData = 18'h0_0000;
		strobe = 1'b0;
	end
	task automatic put(input logic [17:0] w);
		aData <= w;
		bData <= w;
		repeat (2) @(posedge mclk);
		strobe <= 1'b1;
		repeat (4) @(posedge mclk);
		strobe <= 1'b0;
		repeat (4) @(posedge mclk);
		aData <= ~w;
		bData <= ~w;
		// let an edge pass before the next word
		@(posedge mclk);
	endtask
endmodule // dpdp_host_model

// >>> test/testbench.sv
// Purpose: self-checking bench of the data path
// Assumes: zero wait bus answers
// Notes: inputs change by nba at edges
module testbench;
	import dpdp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0000_0000, hrdata, v;
	logic hreadyout, hresp, firstPortOe_n, secondPortOe_n, wordStrobe;
	logic driveRun, parityCheckEnable, irq;
	logic [17:0] firstPortIn, secondPortIn, firstPortOut, secondPortOut;
	logic [15:0] driveControlIn = 16'h0000;
	dpdp_strap_t straps = 5'h00;
	int fails = 0, checked = 0;
	assign hready = hreadyout;
	always #10 mclk = ~mclk;
	dual_port_data_path uut (.*);
	dpdp_host_model host (.mclk(mclk), .aData(firstPortIn),
		.bData(secondPortIn), .strobe(wordStrobe));
	////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		v = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(v, e);
	endtask
	task settle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task t_regs;
		rdchk(8'h40, 32'h0000_0000);
		wr(8'h10, 32'h0000_00A5);
		wr(8'h14, 32'h0000_003C);
		wr(8'h00, 32'h0000_0080);
		rdchk(8'h1C, 32'h0000_00A5);
		wr(8'h00, 32'h0000_00A0);
		rdchk(8'h1C, 32'h0000_003C);
		wr(8'h00, 32'h0000_0000);
		rdchk(8'h1C, 32'h0000_0000);
		$display("test regs done");
	endtask
	task t_ports;
		wr(8'h18, 32'h0003_1234);
		wr(8'h00, 32'h0000_00C0);
		rdchk(8'h1C, 32'h0000_1234);
		settle(3);
		chk(32'(firstPortOut), 32'h0000_1234);
		driveControlIn <= 16'hBEEF;
		settle(6);
		wr(8'h00, 32'h0000_00E0);
		rdchk(8'h1C, 32'h0000_BEEF);
		wr(8'h00, 32'h0000_0007);
		settle(3);
		chk(32'({firstPortOe_n, secondPortOe_n}), 32'h0000_0001);
		chk(32'(firstPortOut), 32'h0003_1234);
		wr(8'h00, 32'h0000_0005);
		settle(3);
		chk(32'({firstPortOe_n, secondPortOe_n}), 32'h0000_0002);
		chk(32'(secondPortOut), 32'h0003_1234);
		wr(8'h00, 32'h0000_0003);
		settle(3);
		chk(32'({firstPortOe_n, secondPortOe_n}), 32'h0000_0003);
		$display("test ports done");
	endtask
	task t_parity;
		straps <= 5'h19;
		wr(8'h00, 32'h0000_000B);
		settle(6);
		chk(32'(parityCheckEnable), 32'h0000_0001);
		host.put(18'h2_0000);
		rdchk(8'h08, 32'h0000_0001);
		rdchk(8'h18, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		wr(8'h0C, 32'h0000_0001);
		settle(3);
		chk(32'(irq), 32'h0000_0001);
		wr(8'h08, 32'h0000_0001);
		settle(3);
		chk(32'(irq), 32'h0000_0000);
		wr(8'h0C, 32'h0000_0000);
		straps <= 5'h09;
		wr(8'h00, 32'h0000_0009);
		settle(6);
		chk(32'(parityCheckEnable), 32'h0000_0000);
		host.put(18'h3_0005);
		rdchk(8'h18, 32'h0003_0005);
		host.put(18'h2_0000);
		rdchk(8'h08, 32'h0000_0000);
		straps <= 5'h11;
		wr(8'h00, 32'h0000_000B);
		settle(6);
		host.put(18'h3_0006);
		rdchk(8'h18, 32'h0003_0006);
		$display("test parity done");
	endtask
	task t_start;
		int thr;
		for (int i = 0; i < 4; i++) begin
			straps <= 5'(5'h04 >> i);
			thr = (i == 3) ? 1 : 64 >> i;
			settle(6);
			wr(8'h00, 32'h0000_001B);
			settle(2);
			rdchk(8'h04, 32'h0000_0000);
			repeat (thr - 1) host.put(18'h0_0001);
			chk(32'(driveRun), 32'h0000_0000);
			host.put(18'h0_0001);
			chk(32'(driveRun), 32'h0000_0001);
			rdchk(8'h04, 32'h0000_8000 | 32'(thr));
			rdchk(8'h08, 32'h0000_0002);
			wr(8'h08, 32'h0000_0003);
		end
		$display("test start done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#1ms;
		fails++;
		final_report;
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_regs;
		t_ports;
		t_parity;
		t_start;
		final_report;
	end
endmodule // testbench
